// >>> hdl/sample_queue_pkg.sv
/*
 * Shared constants and types of the sensor sample queue: register
 * numbers, field positions, reset values and the register request carrier.
 * Assumes a serial front end that decodes host accesses into one request.
 */
`default_nettype none
package sample_queue_pkg;
    // register numbers as the host addresses them
    localparam logic [6:0] REG_CONFIG        = 7'h1A;
    localparam logic [6:0] REG_CAPTURE_EN    = 7'h23;
    localparam logic [6:0] REG_EVENT_STATUS  = 7'h3A;
    localparam logic [6:0] REG_SENSOR_FIRST  = 7'h3B;
    localparam logic [6:0] REG_SENSOR_LAST   = 7'h48;
    localparam logic [6:0] REG_COUNT_HIGH    = 7'h72;
    localparam logic [6:0] REG_COUNT_LOW     = 7'h73;
    localparam logic [6:0] REG_QUEUE_DATA    = 7'h74;
    localparam logic [6:0] REG_PART_IDENTITY = 7'h75;
    // field positions and widths
    localparam int SENSOR_REGS       = 14;
    localparam int STOP_WHEN_FULL_BIT = 6;
    localparam int OVERFLOW_BIT      = 4;
    localparam int COUNT_W           = 13;
    localparam int COUNT_HIGH_W      = 5;
    localparam int BYTE_W            = 8;
    localparam int QUEUE_DEPTH       = 32;
    // reset values and special bytes
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam logic [7:0] CAPTURE_RESET = 8'h00;
    localparam logic [7:0] EMPTY_MARKER  = 8'hFF;
    localparam logic [7:0] MARKER_SUBST  = 8'hFE;
    // i2c address with the select pin low; pin high adds one
    localparam logic [6:0] I2C_ADDR_BASE = 7'h68;
    localparam logic [3:0] WALK_LAST     = 4'hD;

    typedef struct packed {
        logic [6:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_WALK = 2'b10
    } seq_state_t;
endpackage
`default_nettype wire

// >>> hdl/sensor_sample_queue.sv
/*
 * Byte FIFO and the sensor sample queue with its registers.
 * Assumes a serial front end on the same clock that issues one-cycle read
 * and write strobes, and sensor data registers held steady by the core.
 */
`timescale 1ns/1ns
`default_nettype none

// byte fifo; a pop in the same cycle lets a full fifo accept a push
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    input  wire logic                       flush,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0]           mem_q [DEPTH];
    logic [PW-1:0]              wr_ptr_q;
    logic [PW-1:0]              rd_ptr_q;
    logic [$clog2(DEPTH+1)-1:0] level_q;
    logic                       push;
    logic                       pop;

    assign out_valid = (level_q != '0);
    assign in_ready  = (level_q != DEPTH[$clog2(DEPTH+1)-1:0]) || out_ready;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_ptr_q];
    assign level     = level_q;

    // storage has no reset; only pointers and level carry state
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q  <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                level_q <= level_q + 1'b1;
            end else if (pop && !push) begin
                level_q <= level_q - 1'b1;
            end
        end
    end
endmodule

// Notes on behaviour
// - push enabled registers lowest number first
// - all flags set pushes registers 59..72
// - capture flag in register 35 gates data
// - push beyond capacity sets overflow flag
// - overwrite oldest unless stop-when-full bit set
// - empty queue reads return 0xFF
// - genuine data never equals 0xFF
// - data port reads pop, writes push
// - fixed read-only identity register ignores writes
// - i2c address 0x68 or 0x69 by pin
// - 13-bit count across high and low bytes
// - high byte read snapshots both count bytes
module sensor_sample_queue #(
    parameter logic [7:0] PART_IDENTITY_CODE = 8'h3C // arbitrary value
) (
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    input  wire logic                          register_reset,
    input  wire logic                          sample_tick,
    input  wire logic [13:0][7:0]              sensor_data,
    input  wire sample_queue_pkg::reg_req_t    reg_req,
    output logic [7:0]                         reg_rdata,
    input  wire logic                          address_select_pin,
    output logic [6:0]                         i2c_address
);
    localparam int LW = $clog2(sample_queue_pkg::QUEUE_DEPTH + 1);
    logic [7:0]                          config_q;
    logic [7:0]                          capture_q;
    logic                                queue_overflow_flag;
    logic [sample_queue_pkg::COUNT_W-1:0] count_snap_q;
    logic [7:0]                          reg_rdata_q;
    logic [13:0][7:0]                    snap_q;
    logic [3:0]                          idx_q;
    sample_queue_pkg::seq_state_t        state_q;
    logic                                sel_meta_q;
    logic                                sel_sync_q;
    logic                                fifo_in_valid;
    logic                                fifo_in_ready;
    logic [7:0]                          fifo_in_data;
    logic                                fifo_out_valid;
    logic                                fifo_out_ready;
    logic [7:0]                          fifo_out_data;
    logic [LW-1:0]                       fifo_level;
    logic [sample_queue_pkg::COUNT_W-1:0] count_now;
    logic                                host_wr_data;
    logic                                host_rd_data;
    logic                                walk_want;
    logic                                push_want;
    logic                                stop_full;
    logic                                host_pop;
    logic                                drop_oldest;
    logic                                overflow_hit;
    logic                                queue_full;
    // which capture flag covers sensor register at position idx
    function automatic logic [2:0] capture_bit(input logic [3:0] idx);
        if (idx < 4'd6) begin
            capture_bit = 3'd3;
        end else begin
            capture_bit = 3'd7 - 3'(({28'h0, idx} - 32'd6) >> 1);
        end
    endfunction
    // a genuine 0xFF would look like an empty queue, so it is nudged down
    function automatic logic [7:0] no_marker(input logic [7:0] b);
        no_marker = (b == sample_queue_pkg::EMPTY_MARKER) ? sample_queue_pkg::MARKER_SUBST : b;
    endfunction

    assign host_wr_data = reg_req.wr && (reg_req.addr == sample_queue_pkg::REG_QUEUE_DATA);
    assign host_rd_data = reg_req.rd && (reg_req.addr == sample_queue_pkg::REG_QUEUE_DATA);
    assign stop_full    = config_q[sample_queue_pkg::STOP_WHEN_FULL_BIT];
    assign count_now    = sample_queue_pkg::COUNT_W'(fifo_level);
    assign walk_want    = (state_q == sample_queue_pkg::SEQ_WALK) && capture_q[capture_bit(idx_q)] && !host_wr_data;

    // host write push
    // host writes win the push port; the walk stalls for that cycle
    assign push_want    = host_wr_data || walk_want;
    assign fifo_in_data = no_marker(host_wr_data ? reg_req.wdata : snap_q[idx_q]);
    assign queue_full   = (count_now == sample_queue_pkg::COUNT_W'(sample_queue_pkg::QUEUE_DEPTH));
    assign drop_oldest  = push_want && !stop_full && queue_full;
    assign host_pop     = host_rd_data && fifo_out_valid;
    assign fifo_out_ready = host_pop || drop_oldest;
    assign fifo_in_valid  = push_want;
    assign overflow_hit = push_want && queue_full && !host_pop;
    byte_fifo #(
        .WIDTH (sample_queue_pkg::BYTE_W),
        .DEPTH (sample_queue_pkg::QUEUE_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset_n   (reset_n),
        .flush     (register_reset),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );
    // ascending walk per tick
    // ticks during a walk are ignored; a walk is far shorter than a sample period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= sample_queue_pkg::SEQ_IDLE;
            idx_q   <= 4'h0;
            snap_q  <= '0;
        end else if (register_reset) begin
            state_q <= sample_queue_pkg::SEQ_IDLE;
            idx_q   <= 4'h0;
        end else begin
            case (state_q)
                sample_queue_pkg::SEQ_IDLE: begin
                    if (sample_tick) begin
                        snap_q  <= sensor_data;
                        idx_q   <= 4'h0;
                        state_q <= sample_queue_pkg::SEQ_WALK;
                    end
                end
                sample_queue_pkg::SEQ_WALK: begin
                    if (!host_wr_data) begin
                        if (idx_q == sample_queue_pkg::WALK_LAST) begin
                            state_q <= sample_queue_pkg::SEQ_IDLE;
                        end
                        idx_q <= idx_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= sample_queue_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // writable configuration; identity and status writes fall through
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            config_q  <= sample_queue_pkg::CONFIG_RESET;
            capture_q <= sample_queue_pkg::CAPTURE_RESET;
        end else if (register_reset) begin
            config_q  <= sample_queue_pkg::CONFIG_RESET;
            capture_q <= sample_queue_pkg::CAPTURE_RESET;
        end else if (reg_req.wr) begin
            if (reg_req.addr == sample_queue_pkg::REG_CONFIG) begin
                config_q <= reg_req.wdata;
            end
            if (reg_req.addr == sample_queue_pkg::REG_CAPTURE_EN) begin
                capture_q <= reg_req.wdata;
            end
        end
    end

    // sticky overflow flag
    // cleared by reading status; a new overflow in that cycle keeps it set
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            queue_overflow_flag <= 1'b0;
        end else if (register_reset) begin
            queue_overflow_flag <= 1'b0;
        end else if (overflow_hit) begin
            queue_overflow_flag <= 1'b1;
        end else if (reg_req.rd && (reg_req.addr == sample_queue_pkg::REG_EVENT_STATUS)) begin
            queue_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_snap_q <= '0;
        end else if (reg_req.rd && (reg_req.addr == sample_queue_pkg::REG_COUNT_HIGH)) begin
            count_snap_q <= count_now;
        end
    end

    // read data, registered one cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                sample_queue_pkg::REG_CONFIG:        reg_rdata_q <= config_q;
                sample_queue_pkg::REG_CAPTURE_EN:    reg_rdata_q <= capture_q;
                sample_queue_pkg::REG_EVENT_STATUS: begin
                    reg_rdata_q <= 8'h00;
                    reg_rdata_q[sample_queue_pkg::OVERFLOW_BIT] <= queue_overflow_flag;
                end
                sample_queue_pkg::REG_COUNT_HIGH:    reg_rdata_q <= {3'b000, count_now[12:8]};
                sample_queue_pkg::REG_COUNT_LOW:     reg_rdata_q <= count_snap_q[7:0];
                sample_queue_pkg::REG_QUEUE_DATA: begin
                    reg_rdata_q <= fifo_out_valid ? fifo_out_data : sample_queue_pkg::EMPTY_MARKER;
                end
                sample_queue_pkg::REG_PART_IDENTITY: reg_rdata_q <= PART_IDENTITY_CODE;
                default: begin
                    if (reg_req.addr >= sample_queue_pkg::REG_SENSOR_FIRST
                        && reg_req.addr <= sample_queue_pkg::REG_SENSOR_LAST) begin
                        reg_rdata_q <= sensor_data[4'(reg_req.addr - sample_queue_pkg::REG_SENSOR_FIRST)];
                    end else begin
                        reg_rdata_q <= 8'h00;
                    end
                end
            endcase
        end
    end
    assign reg_rdata = reg_rdata_q;

    // address select pin
    // pin is asynchronous to the clock, so two flops before use
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sel_meta_q <= 1'b0;
            sel_sync_q <= 1'b0;
        end else begin
            sel_meta_q <= address_select_pin;
            sel_sync_q <= sel_meta_q;
        end
    end
    assign i2c_address = sample_queue_pkg::I2C_ADDR_BASE | {6'h00, sel_sync_q};

    a_empty_marker: assert property (@(posedge clock) disable iff (!reset_n)
        host_rd_data && !fifo_out_valid |=> reg_rdata == 8'hFF)
        else $error("empty read did not return the marker");
    a_no_marker_push: assert property (@(posedge clock) disable iff (!reset_n)
        fifo_in_valid && fifo_in_ready |-> fifo_in_data != 8'hFF)
        else $error("marker byte entered the queue");
    a_overflow_sets: assert property (@(posedge clock) disable iff (!reset_n)
        overflow_hit && !register_reset |=> queue_overflow_flag)
        else $error("overflow flag not set");
    a_stop_keeps_data: assert property (@(posedge clock) disable iff (!reset_n)
        stop_full && count_now == 13'd32 && !host_pop && !register_reset
        |=> count_now == 13'd32 && $stable(u_fifo.rd_ptr_q))
        else $error("stop mode overwrote queued data");
    a_overwrite_oldest: assert property (@(posedge clock) disable iff (!reset_n)
        push_want && !stop_full && count_now == 13'd32 && !host_pop |-> fifo_out_ready && fifo_in_ready)
        else $error("overwrite mode did not drop the oldest byte");
    a_capture_gate: assert property (@(posedge clock) disable iff (!reset_n)
        fifo_in_valid && !host_wr_data |-> capture_q[idx_q <= 4'd5 ? 3'd3 : idx_q <= 4'd7 ? 3'd7
            : idx_q <= 4'd9 ? 3'd6 : idx_q <= 4'd11 ? 3'd5 : 3'd4])
        else $error("byte pushed with its capture flag clear");
    a_walk_order: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == sample_queue_pkg::SEQ_WALK && !host_wr_data && idx_q != 4'hD && !register_reset
        |=> idx_q == $past(idx_q) + 4'h1)
        else $error("walk skipped or reversed");
    a_walk_span: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == sample_queue_pkg::SEQ_IDLE && sample_tick && !register_reset
        |=> idx_q == 4'h0 ##[13:200] state_q == sample_queue_pkg::SEQ_IDLE)
        else $error("walk did not cover the sensor span");
    a_identity_fixed: assert property (@(posedge clock) disable iff (!reset_n)
        reg_req.rd && reg_req.addr == 7'h75 |=> reg_rdata == PART_IDENTITY_CODE)
        else $error("identity register changed");
    a_count_coherent: assert property (@(posedge clock) disable iff (!reset_n)
        reg_req.rd && reg_req.addr == 7'h72 |=> {reg_rdata[4:0], count_snap_q[7:0]} == 13'($past(fifo_level)))
        else $error("count bytes not snapshotted together");
    a_reset_empties: assert property (@(posedge clock) disable iff (!reset_n)
        register_reset |=> fifo_level == '0 && !queue_overflow_flag)
        else $error("register reset left queue state");
    a_i2c_address: assert property (@(posedge clock) disable iff (!reset_n)
        i2c_address == (sel_sync_q ? 7'h69 : 7'h68))
        else $error("wrong i2c address");
endmodule
`default_nettype wire

// >>> testbench/host_port_model.sv
/*
 * Behavioural host on the far side of the register port: issues one-cycle
 * read and write strobes and reads the split queue count.
 * Assumes the register answer appears one cycle after the read strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
    input  wire logic                       clock,
    input  wire logic [7:0]                 reg_rdata,
    output var  sample_queue_pkg::reg_req_t reg_req
);
    // idle request at time zero
    initial begin
        reg_req = '0;
    end

    task automatic write_reg(input logic [6:0] a, input logic [7:0] v);
        @(posedge clock);
        #1;
        reg_req.addr  = a;
        reg_req.wdata = v;
        reg_req.wr    = 1'b1;
        @(posedge clock);
        #1;
        reg_req.wr    = 1'b0;
        reg_req.addr  = ~a; // released lines do not keep the old value
        reg_req.wdata = ~v;
    endtask

    task automatic read_reg(input logic [6:0] a, output logic [7:0] v);
        @(posedge clock);
        #1;
        reg_req.addr = a;
        reg_req.rd   = 1'b1;
        @(posedge clock);
        #1;
        v            = reg_rdata;
        reg_req.rd   = 1'b0;
        reg_req.addr = ~a;
    endtask

    task automatic read_count(output logic [12:0] c);
        logic [7:0] h;
        logic [7:0] l;
        read_reg(sample_queue_pkg::REG_COUNT_HIGH, h);
        read_reg(sample_queue_pkg::REG_COUNT_LOW, l);
        c = {h[4:0], l};
    endtask
endmodule
`default_nettype wire

// >>> testbench/sensor_sample_queue_bench.sv
/*
 * Self-checking bench of the sensor sample queue: identity, address pin,
 * sample walks, overflow in both modes and register reset.
 * Assumes the host model drives the register port.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module sensor_sample_queue_bench;
    localparam logic [7:0] ID_CODE = 8'h5A; // arbitrary value
    logic                       clock;
    logic                       reset_n;
    logic                       register_reset;
    logic                       sample_tick;
    logic [13:0][7:0]           sensor_data;
    sample_queue_pkg::reg_req_t reg_req;
    logic [7:0]                 reg_rdata;
    logic                       address_select_pin;
    logic [6:0]                 i2c_address;
    logic [7:0]                 d;
    logic [12:0]                c;
    int                         n_errors;
    int                         check_count;
    int                         bitn [5] = '{3, 7, 6, 5, 4};
    int                         lo [5]   = '{0, 6, 8, 10, 12};
    int                         hi [5]   = '{5, 7, 9, 11, 13};

    sensor_sample_queue #(.PART_IDENTITY_CODE(ID_CODE)) dut (
        .clock(clock), .reset_n(reset_n), .register_reset(register_reset),
        .sample_tick(sample_tick), .sensor_data(sensor_data), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .address_select_pin(address_select_pin), .i2c_address(i2c_address)
    );
    host_port_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_req(reg_req));

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic end_of_test();
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one tick, then the 14-cycle walk plus margin
    task automatic tick_walk();
        @(posedge clock);
        #1 sample_tick = 1'b1;
        @(posedge clock);
        #1 sample_tick = 1'b0;
        repeat (16) @(posedge clock);
    endtask

    task automatic expect_count(input logic [12:0] n);
        host.read_count(c);
        `CHECK(c, n)
    endtask

    task automatic pop_expect(input logic [7:0] e);
        host.read_reg(sample_queue_pkg::REG_QUEUE_DATA, d);
        `CHECK(d, e)
    endtask

    task automatic expect_overflow(input logic e);
        host.read_reg(sample_queue_pkg::REG_EVENT_STATUS, d);
        `CHECK(d[sample_queue_pkg::OVERFLOW_BIT], e)
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        end_of_test();
    end

    initial begin
        {reset_n, register_reset, sample_tick, address_select_pin} = 4'h0;
        for (int i = 0; i < 14; i++) sensor_data[i] = 8'h10 + 8'(i);
        sensor_data[5] = 8'hFF;
        repeat (6) @(posedge clock);
        #1 reset_n = 1'b1;
        host.read_reg(sample_queue_pkg::REG_PART_IDENTITY, d);
        `CHECK(d, ID_CODE)
        host.write_reg(sample_queue_pkg::REG_PART_IDENTITY, ~ID_CODE);
        host.read_reg(sample_queue_pkg::REG_PART_IDENTITY, d);
        `CHECK(d, ID_CODE)
        `CHECK(i2c_address, 7'h68)
        @(posedge clock);
        #1 address_select_pin = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        `CHECK(i2c_address, 7'h69)
        pop_expect(8'hFF);
        expect_count(13'h0000);
        // the high byte read freezes the low byte; a host 0xFF comes back as 0xFE
        host.read_reg(sample_queue_pkg::REG_COUNT_HIGH, d);
        host.write_reg(sample_queue_pkg::REG_QUEUE_DATA, 8'hFF);
        host.read_reg(sample_queue_pkg::REG_COUNT_LOW, d);
        `CHECK(d, 8'h00)
        expect_count(13'h0001);
        pop_expect(8'hFE);
        pop_expect(8'hFF);
        // all capture flags: full span in register order, marker substituted
        host.write_reg(sample_queue_pkg::REG_CAPTURE_EN, 8'hF8);
        tick_walk();
        expect_count(13'h000E);
        for (int i = 0; i < 14; i++) pop_expect(i == 5 ? 8'hFE : 8'h10 + 8'(i));
        pop_expect(8'hFF);
        // each capture flag alone gates only its registers
        sensor_data[5] = 8'h15;
        for (int k = 0; k < 5; k++) begin
            host.write_reg(sample_queue_pkg::REG_CAPTURE_EN, 8'h01 << bitn[k]);
            tick_walk();
            expect_count(13'(hi[k] - lo[k] + 1));
            for (int j = lo[k]; j <= hi[k]; j++) pop_expect(8'h10 + 8'(j));
            pop_expect(8'hFF);
        end
        // overwrite mode: 33 host pushes drop the oldest byte
        host.write_reg(sample_queue_pkg::REG_CAPTURE_EN, 8'h00);
        for (int i = 0; i < 33; i++) host.write_reg(sample_queue_pkg::REG_QUEUE_DATA, 8'(i));
        expect_overflow(1'b1);
        expect_overflow(1'b0);
        expect_count(13'h0020);
        for (int i = 1; i < 33; i++) pop_expect(8'(i));
        pop_expect(8'hFF);
        // stop mode: the extra byte is dropped, queued data kept
        host.write_reg(sample_queue_pkg::REG_CONFIG, 8'h40);
        host.read_reg(sample_queue_pkg::REG_CONFIG, d);
        `CHECK(d, 8'h40)
        for (int i = 0; i < 33; i++) host.write_reg(sample_queue_pkg::REG_QUEUE_DATA, 8'h40 + 8'(i));
        expect_overflow(1'b1);
        expect_count(13'h0020);
        pop_expect(8'h40);
        // refill past full, then register reset
        host.write_reg(sample_queue_pkg::REG_QUEUE_DATA, 8'h01);
        host.write_reg(sample_queue_pkg::REG_QUEUE_DATA, 8'h02);
        @(posedge clock);
        #1 register_reset = 1'b1;
        @(posedge clock);
        #1 register_reset = 1'b0;
        expect_overflow(1'b0);
        expect_count(13'h0000);
        pop_expect(8'hFF);
        host.read_reg(sample_queue_pkg::REG_CONFIG, d);
        `CHECK(d, 8'h00)
        end_of_test();
    end
endmodule
`default_nettype wire
